/* File: psf_pkg.sv */
// program status flags: shared constants and carrier types
// assumes a single cpu clock domain; bit positions follow the status word layout
package psf_pkg;
   localparam int          PSF_W        = 32;            // status word width
   localparam logic [4:0]  PSF_SYSREG_NO = 5'h05;        // system register number of the word
   localparam int          PSF_BIT_STEP = 11;            // single-step flag
   localparam int          PSF_BIT_NMI  = 7;             // nmi_active_flag
   localparam int          PSF_BIT_EXC  = 6;             // exception_active_flag
   localparam int          PSF_BIT_DIS  = 5;             // irq_disable_flag
   localparam int          PSF_LOW_W    = 5;             // result flags, bits 4..0
   localparam logic [31:0] PSF_WR_MASK  = 32'h0000_08ff; // writable bits; 31..12, 10..8 reserved
   localparam logic [31:0] PSF_RESET    = 32'h0000_0020; // irq_disable_flag set after reset

   // sysreg_load_instr as seen by the status word
   typedef struct packed {
      logic        exec;  // load executing (may span cycles)
      logic        done;  // load completes this cycle
      logic [4:0]  regno; // target system register number
      logic [31:0] data;  // value written
   } psf_load_t;

   // requests and pipeline events
   typedef struct packed {
      logic irq_req; // maskable interrupt request
      logic nmi_req; // non-maskable interrupt request
      logic exc_req; // exception taken this cycle
      logic retire;  // an instruction finished executing
   } psf_evt_t;
endpackage

/* File: psf_flag.sv */
// single status flag cell with load, hardware set/clear and a forced-zero hold
// assumes the caller resolves which events apply in a given cycle
`timescale 1ns/1ps
module psf_flag #(
   parameter logic RESET_VAL = 1'b0  // value after reset
) (
   input  wire logic clk_sys,    // cpu clock
   input  wire logic resetn,     // async reset, active low
   input  wire logic ld_en,      // software load this cycle
   input  wire logic ld_val,     // value loaded
   input  wire logic hw_set,     // hardware set
   input  wire logic hw_clr,     // hardware clear
   input  wire logic hold_zero,  // force the flag to 0
   output logic      flag_q      // flag state
);
   logic flag_d;

   // priority: hold, then hardware set, hardware clear, load; events never lost to a load
   always_comb begin
      flag_d = flag_q;
      if (hold_zero) begin
         flag_d = 1'b0;
      end else if (hw_set) begin
         flag_d = 1'b1;
      end else if (hw_clr) begin
         flag_d = 1'b0;
      end else if (ld_en) begin
         flag_d = ld_val;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         flag_q <= RESET_VAL;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule

/* File: psf_status.sv */
// program status word: control flags, interrupt gating and single-step traps
// assumes requests are synchronous to clk_sys and that the pipeline holds an
// acknowledged request's entry in the same cycle as the ack
`timescale 1ns/1ps
module psf_status
   import psf_pkg::*;
#(
   parameter int WORD_W = PSF_W  // status word width
) (
   input  wire logic      clk_sys,               // cpu clock, 40 MHz
   input  wire logic      resetn,                // async reset, active low
   input  wire psf_load_t sysreg_load_instr,     // system register load
   input  wire psf_evt_t  evt,                   // requests and pipeline events
   input  wire logic      step_permit_bit,       // step enable from debug register
   output logic [31:0]    program_status_word,   // current word, for the store path
   output logic           irq_ack,               // maskable interrupt accepted
   output logic           nmi_ack,               // nmi accepted
   output logic           step_trap_q,           // debug trap pulse after a step
   output logic           irq_disable_flag,      // interrupts masked
   output logic           nmi_active_flag,       // nmi servicing in progress
   output logic           exception_active_flag  // exception servicing in progress
);
   logic                 ld_word;
   logic                 ld_dis_block;
   logic                 any_entry;
   logic                 step_q;
   logic                 nmi_q;
   logic                 exc_q;
   logic                 dis_q;
   logic [PSF_LOW_W-1:0] low_q;

   // the datapath is built for a 32-bit word only
   if (WORD_W != 32) begin : g_bad_width
      $error("psf_status: WORD_W must be 32");
   end

   // a load aimed at the status word
   assign ld_word = sysreg_load_instr.done && (sysreg_load_instr.regno == PSF_SYSREG_NO);

   // look at the load's data while it executes so masking starts before it completes
   assign ld_dis_block = sysreg_load_instr.exec &&
                         (sysreg_load_instr.regno == PSF_SYSREG_NO) &&
                         sysreg_load_instr.data[PSF_BIT_DIS];

   // acceptance: nmi unless one is in service, irq also needs the mask clear
   assign nmi_ack = evt.nmi_req && !nmi_q;
   assign irq_ack = evt.irq_req && !evt.nmi_req && !dis_q && !nmi_q &&
                    !ld_dis_block;

   // every branch into a handler
   assign any_entry = irq_ack || nmi_ack || evt.exc_req;

   // single-step flag at bit 11; cleared on entry, held low without permit
   psf_flag #(.RESET_VAL(PSF_RESET[PSF_BIT_STEP])) u_step (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .ld_en     (ld_word),
      .ld_val    (sysreg_load_instr.data[PSF_BIT_STEP]),
      .hw_set    (1'b0),
      .hw_clr    (any_entry),
      .hold_zero (!step_permit_bit),
      .flag_q    (step_q)
   );

   // nmi in service; only software clears it, typically on return
   psf_flag #(.RESET_VAL(PSF_RESET[PSF_BIT_NMI])) u_nmi (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .ld_en     (ld_word),
      .ld_val    (sysreg_load_instr.data[PSF_BIT_NMI]),
      .hw_set    (nmi_ack),
      .hw_clr    (1'b0),
      .hold_zero (1'b0),
      .flag_q    (nmi_q)
   );

   // exception in service; does not mask maskable interrupts
   psf_flag #(.RESET_VAL(PSF_RESET[PSF_BIT_EXC])) u_exc (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .ld_en     (ld_word),
      .ld_val    (sysreg_load_instr.data[PSF_BIT_EXC]),
      .hw_set    (evt.exc_req),
      .hw_clr    (1'b0),
      .hold_zero (1'b0),
      .flag_q    (exc_q)
   );

   // interrupt mask; raised on irq and nmi entry so handlers start masked
   psf_flag #(.RESET_VAL(PSF_RESET[PSF_BIT_DIS])) u_dis (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .ld_en     (ld_word),
      .ld_val    (sysreg_load_instr.data[PSF_BIT_DIS]),
      .hw_set    (irq_ack || nmi_ack),
      .hw_clr    (1'b0),
      .hold_zero (1'b0),
      .flag_q    (dis_q)
   );

   // result flags are only kept here; their arithmetic updates live elsewhere
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         low_q <= PSF_RESET[PSF_LOW_W-1:0];
      end else if (ld_word) begin
         low_q <= sysreg_load_instr.data[PSF_LOW_W-1:0];
      end
   end

   // trap after each instruction retired while stepping; an entry that
   // retires in the same cycle still traps, the flag drops afterwards
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         step_trap_q <= 1'b0;
      end else begin
         step_trap_q <= evt.retire && step_q;
      end
   end

   // reserved fields are constant zero, so a write can never reach them
   always_comb begin
      program_status_word                 = 32'h0000_0000;
      program_status_word[PSF_BIT_STEP]   = step_q;
      program_status_word[PSF_BIT_NMI]    = nmi_q;
      program_status_word[PSF_BIT_EXC]    = exc_q;
      program_status_word[PSF_BIT_DIS]    = dis_q;
      program_status_word[PSF_LOW_W-1:0]  = low_q;
   end

   assign irq_disable_flag      = dis_q;
   assign nmi_active_flag       = nmi_q;
   assign exception_active_flag = exc_q;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_load_effect: assert property (
      (ld_word && !any_entry && step_permit_bit) |=>
         (program_status_word == ($past(sysreg_load_instr.data) & PSF_WR_MASK)))
      else $error("loaded status word not effective next cycle");

   a_load_block: assert property (
      (sysreg_load_instr.exec && (sysreg_load_instr.regno == PSF_SYSREG_NO) &&
       sysreg_load_instr.data[PSF_BIT_DIS]) |-> !irq_ack)
      else $error("irq accepted while load sets disable flag");

   a_rsvd_zero: assert property (
      (program_status_word & ~PSF_WR_MASK) == 32'h0000_0000)
      else $error("reserved status bits not zero");

   a_step_trap: assert property (
      (evt.retire && program_status_word[PSF_BIT_STEP]) |=> step_trap_q ##1
         (step_trap_q == $past(evt.retire && program_status_word[PSF_BIT_STEP])))
      else $error("single-step trap missing or wrong");

   a_entry_clr_ss: assert property (
      any_entry |=> !program_status_word[PSF_BIT_STEP])
      else $error("single-step not cleared on handler entry");

   a_permit_hold: assert property (
      !step_permit_bit |=> !program_status_word[PSF_BIT_STEP])
      else $error("single-step set without permit");

   a_nmi_nesting: assert property (
      nmi_ack |=> nmi_active_flag && !irq_ack && !nmi_ack)
      else $error("nmi flag not set or nesting allowed");

   a_nmi_report: assert property (
      (!nmi_active_flag && !nmi_ack && !ld_word) |=> !nmi_active_flag)
      else $error("nmi flag set without nmi acknowledge");

   a_exc_irq: assert property (
      (exception_active_flag && evt.irq_req && !evt.nmi_req && !irq_disable_flag &&
       !nmi_active_flag && !sysreg_load_instr.exec) |-> irq_ack)
      else $error("irq refused during exception servicing");

   a_id_mask: assert property (
      irq_disable_flag |-> !irq_ack)
      else $error("irq accepted while disabled");

   c_irq_taken: cover property (irq_ack ##1 irq_disable_flag);
   c_nmi_taken: cover property (nmi_ack ##1 nmi_active_flag);
   c_step_run:  cover property (step_trap_q ##1 step_trap_q);
   c_load_blk:  cover property (evt.irq_req && ld_dis_block);
endmodule

/* File: psf_partner.sv */
// partner: interrupt request source facing the status word
// assumes requests change only on the rising edge of clk_sys
`timescale 1ns/1ps
module psf_partner (
   input  wire logic clk_sys,  // cpu clock
   input  wire logic resetn,   // async reset, active low
   input  wire logic irq_go,   // raise maskable request
   input  wire logic nmi_go,   // raise nmi request
   input  wire logic drop,     // withdraw refused requests
   input  wire logic irq_ack,  // maskable ack
   input  wire logic nmi_ack,  // nmi ack
   output logic      irq_req,  // maskable request, level
   output logic      nmi_req   // nmi request, level
);
   // a request holds until acked at an edge; refused ones wait for drop
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         irq_req <= 1'b0;
         nmi_req <= 1'b0;
      end else begin
         irq_req <= irq_go | (irq_req & !irq_ack & !drop);
         nmi_req <= nmi_go | (nmi_req & !nmi_ack & !drop);
      end
   end
endmodule

/* File: program_status_flags_test.sv */
// testbench for the status word: loads, requests, exceptions, stepping
// assumes psf_partner stands in for the request logic
`timescale 1ns/1ps
module program_status_flags_test;
   import psf_pkg::*;
   logic        clk_sys, resetn, permit, irq_go, nmi_go, drop, exc, ret;
   logic        irq_req, nmi_req, irq_ack, nmi_ack, trap, dis_f, nmi_f, exc_f;
   logic [31:0] word;
   psf_load_t   ld;
   psf_evt_t    evt;
   int          miscompares, comparisons;

   assign evt = '{irq_req: irq_req, nmi_req: nmi_req, exc_req: exc, retire: ret};
   psf_status #(.WORD_W(32)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
      .sysreg_load_instr(ld), .evt(evt), .step_permit_bit(permit),
      .program_status_word(word), .irq_ack(irq_ack), .nmi_ack(nmi_ack),
      .step_trap_q(trap), .irq_disable_flag(dis_f), .nmi_active_flag(nmi_f),
      .exception_active_flag(exc_f));
   psf_partner u_src (.clk_sys(clk_sys), .resetn(resetn), .irq_go(irq_go),
      .nmi_go(nmi_go), .drop(drop), .irq_ack(irq_ack), .nmi_ack(nmi_ack),
      .irq_req(irq_req), .nmi_req(nmi_req));

   // inputs move 1 ns after the edge so sampling never races
   task automatic tick(int n = 1);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one load edge, then an idle edge so back-to-back loads never rewrite ld at once
   task automatic load(logic [31:0] d, logic [4:0] rn = PSF_SYSREG_NO);
      ld = '{exec: 1'b1, done: 1'b1, regno: rn, data: d};
      tick();
      ld = '0;
      tick();
   endtask
   // one go cycle; the request is live after return
   task automatic req(logic nmi);
      nmi_go = nmi;
      irq_go = !nmi;
      tick();
      nmi_go = 1'b0;
      irq_go = 1'b0;
   endtask
   task automatic report_and_stop();
      $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // whole run is under 60 cycles
   initial begin
      #20000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      {resetn, permit, irq_go, nmi_go, drop, exc, ret} = '0;
      ld = '0;
      tick(2);
      resetn = 1'b1;
      chk(word, 32'h0000_0020, "reset word");
      permit = 1'b1;
      load(32'hffff_ffff, 5'h06);
      chk(word, 32'h0000_0020, "other register ignored");
      load(32'hffff_ffff);
      chk(word, 32'h0000_08ff, "reserved bits");
      permit = 1'b0;
      load(32'hffff_ffff);
      chk(word, 32'h0000_00ff, "permit low");
      permit = 1'b1;
      $display("test load done");
      // disable set by a load that is still executing
      load(32'h0);
      irq_go = 1'b1;
      ld = '{exec: 1'b1, done: 1'b0, regno: PSF_SYSREG_NO, data: 32'h20};
      tick();
      irq_go = 1'b0;
      chk(irq_ack, 1'b0, "load masks irq");
      ld.done = 1'b1;
      tick();
      ld = '0;
      drop = 1'b1;
      tick();
      drop = 1'b0;
      chk(word, 32'h20, "load sets id");
      load(32'h0);
      req(1'b0);
      chk(irq_ack, 1'b1, "irq ack");
      tick();
      chk({irq_ack, dis_f}, 2'b01, "mask after ack");
      load(32'h0);
      exc = 1'b1;
      tick();
      exc = 1'b0;
      chk(exc_f, 1'b1, "exc flag");
      req(1'b0);
      chk(irq_ack, 1'b1, "irq under exc");
      tick();
      $display("test irq done");
      req(1'b1);
      chk(nmi_ack, 1'b1, "nmi ack");
      tick();
      chk({nmi_ack, nmi_f}, 2'b01, "nmi flag");
      load(32'h80);
      req(1'b0);
      chk(irq_ack, 1'b0, "no nesting");
      drop = 1'b1;
      load(32'h0);
      drop = 1'b0;
      chk(nmi_f, 1'b0, "nmi flag clear");
      $display("test nmi done");
      load(32'h800);
      ret = 1'b1;
      tick();
      ret = 1'b0;
      chk(trap, 1'b1, "step trap");
      tick();
      chk(trap, 1'b0, "single trap");
      req(1'b0);
      tick();
      chk(word, 32'h20, "entry clears step");
      $display("test step done");
      report_and_stop();
   end
endmodule
